/* rtl/uwr_rx.sv */
// Purpose: Receiver with stop-bit checks, in-frame resync, standby wakeup and input routing
// Assumes: i_sample_tick pulses once per sample at 16x the bit rate
// Notes:   Received words pass through a two-entry buffer
`timescale 1ns/100ps
module uwr_rx (
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_ce,
	input  wire logic                       i_sample_tick,
	input  wire logic                       i_rx_pin,
	input  wire logic                       i_tx_pin,
	input  wire logic                       i_tx_out,
	output logic                            o_tx_pin,
	output logic                            o_tx_pin_oe_n,
	input  wire uwr_pkg::uwr_route_cfg_type i_cfg,
	input  wire logic                       i_receiver_enable,
	input  wire logic                       i_nine_bit,
	input  wire logic                       i_wake_select,
	input  wire logic                       i_idle_count_start_select,
	input  wire logic                       i_standby_set,
	input  wire logic                       i_standby_clr,
	input  wire logic                       i_idle_clr,
	input  wire logic                       i_overrun_clr,
	input  wire logic                       i_rx_irq_enable,
	input  wire logic                       i_idle_irq_enable,
	output uwr_pkg::uwr_rx_word_type        o_rx_word,
	output logic                            o_rx_valid,
	input  wire logic                       i_rx_ready,
	output logic                            o_receive_full_flag,
	output logic                            o_idle_flag,
	output logic                            o_overrun,
	output logic                            o_standby_request,
	output logic                            o_rx_irq
);
	import uwr_pkg::*;

	function automatic logic maj3(input logic a, input logic b, input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction

	function automatic logic same3(input logic a, input logic b, input logic c);
		same3 = (a == b) && (b == c);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic            tk;
	logic            rx_line;
	uwr_state_type   state;
	logic [4:0]      rt;
	logic [3:0]      bit_idx;
	logic [2:0]      hist;
	logic [1:0]      smp;
	logic            last_bit;
	logic            prev_s;
	logic [8:0]      data;
	logic            noise;
	logic [7:0]      ft;
	logic            resynced;
	logic [7:0]      idle_cnt;
	logic            idle_armed;
	logic            standby;
	uwr_rx_word_type pend;
	logic            pend_v;
	logic            buf_ready;
	logic [3:0]      nbits;
	logic [7:0]      idle_thr;
	logic            vote;
	logic            fall;
	logic            late;
	logic            early;
	logic            data_dec;
	logic            stop_first;
	logic            stop_dec;
	logic            addr_hit;
	logic            line_idle;
	logic            wake_idle;
	logic            idle_set;
	logic            in_frame;

	assign tk = i_ce && i_sample_tick;
	assign nbits = i_nine_bit ? BITS_9 : BITS_8;
	assign idle_thr = i_nine_bit ? IDLE_TICKS_9 : IDLE_TICKS_8;
	assign in_frame = state == ST_DATA || state == ST_STOP;
	assign vote = maj3(smp[0], smp[1], rx_line);
	assign data_dec = tk && state == ST_DATA && rt == RT_S3;
	assign stop_first = tk && state == ST_STOP && rt == RT_S1;
	assign stop_dec = tk && state == ST_STOP && rt == RT_S3;

	// Edge is valid only after a bit already decided as one
	assign fall = tk && in_frame && prev_s && !rx_line && last_bit;
	assign late = fall && rt > RT_FIRST && rt < RT_S1;
	assign early = fall && state == ST_DATA && rt > RT_S3;

	// Last data bit is the MSB for either length
	assign addr_hit = data_dec && bit_idx == nbits && vote && standby &&
		i_wake_select == WAKE_ADDR;

	assign line_idle = idle_cnt >= idle_thr;
	assign wake_idle = standby && i_wake_select == WAKE_IDLE && line_idle;
	assign idle_set = idle_armed && line_idle && !standby;

	////////////////////////////////////////////////////////////////////////////
	uwr_route u_route (
		.i_rx_pin      (i_rx_pin),
		.i_tx_pin      (i_tx_pin),
		.i_tx_out      (i_tx_out),
		.i_cfg         (i_cfg),
		.o_rx_line     (rx_line),
		.o_tx_pin      (o_tx_pin),
		.o_tx_pin_oe_n (o_tx_pin_oe_n)
	);

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer and tick counter
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_HUNT;
			rt <= RT_FIRST;
			bit_idx <= 4'h0;
			resynced <= 1'b0;
		end else if (i_ce) begin
			if (!i_receiver_enable) begin
				state <= ST_HUNT;
			end else if (tk) begin
				case (state)
					ST_HUNT: begin
						if (hist == HIST_ONES && !rx_line) begin
							state <= ST_START;
							rt <= RT_NEXT;
							resynced <= 1'b0;
						end
					end
					ST_START: begin
						if (rt == RT_V3 && maj3(smp[0], smp[1], rx_line)) begin
							state <= ST_HUNT;
						end else if (rt == RT_LAST) begin
							state <= ST_DATA;
							rt <= RT_FIRST;
							bit_idx <= IDX_STEP;
						end else begin
							rt <= rt + RT_STEP;
						end
					end
					ST_DATA: begin
						if (late) begin
							rt <= RT_NEXT;
							resynced <= 1'b1;
						end else if (early || rt == RT_LAST) begin
							rt <= early ? RT_NEXT : RT_FIRST;
							resynced <= resynced | early;
							bit_idx <= bit_idx + IDX_STEP;
							if (bit_idx == nbits) begin
								state <= ST_STOP;
							end
						end else begin
							rt <= rt + RT_STEP;
						end
					end
					ST_STOP: begin
						if (late) begin
							rt <= RT_NEXT;
							resynced <= 1'b1;
						end else if (rt == RT_S3) begin
							state <= ST_HUNT;
						end else begin
							rt <= rt + RT_STEP;
						end
					end
					default: begin
						state <= ST_HUNT;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Line samples, votes and shifted data
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			hist <= 3'h0;
			smp <= 2'h0;
			prev_s <= 1'b1;
			last_bit <= 1'b0;
			data <= 9'h000;
			noise <= 1'b0;
		end else if (tk) begin
			hist <= {hist[1:0], rx_line};
			prev_s <= rx_line;
			if (state == ST_HUNT) begin
				data <= 9'h000;
				noise <= 1'b0;
				last_bit <= 1'b0;
			end else if (state == ST_START) begin
				if (rt == RT_V1) begin
					smp[0] <= rx_line;
				end
				if (rt == RT_V2) begin
					smp[1] <= rx_line;
				end
				if (rt == RT_V3) begin
					noise <= smp[0] | smp[1] | rx_line;
				end
			end else begin
				if (rt == RT_S1) begin
					smp[0] <= rx_line;
				end
				if (rt == RT_S2) begin
					smp[1] <= rx_line;
				end
				if (data_dec) begin
					data[4'(bit_idx - IDX_STEP)] <= vote;
					last_bit <= vote;
					noise <= noise | !same3(smp[0], smp[1], rx_line);
				end
			end
		end
	end

	// Helper for stop timing; counts ticks since the start edge
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ft <= 8'h00;
		end else if (tk) begin
			ft <= (state == ST_HUNT) ? CNT_STEP : ft + CNT_STEP;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Completed frame, framing and noise decisions
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pend <= '0;
			pend_v <= 1'b0;
		end else if (i_ce) begin
			pend_v <= stop_dec;
			if (stop_dec) begin
				pend.data <= data;
				pend.noise <= noise | !same3(smp[0], smp[1], rx_line);
				pend.framing <= !vote;
				pend.full <= !standby;
			end
		end
	end

	// A word the buffer cannot take is dropped and reported
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_overrun <= 1'b0;
		end else if (i_ce) begin
			if (pend_v && !buf_ready) begin
				o_overrun <= 1'b1;
			end else if (i_overrun_clr) begin
				o_overrun <= 1'b0;
			end
		end
	end

	uwr_buf2 u_buf (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_ce      (i_ce),
		.i_valid   (pend_v),
		.o_ready   (buf_ready),
		.i_word    (pend),
		.o_valid   (o_rx_valid),
		.i_ready   (i_rx_ready),
		.o_word    (o_rx_word)
	);

	assign o_receive_full_flag = o_rx_valid && o_rx_word.full;

	////////////////////////////////////////////////////////////////////////////
	// Standby; a software set wins over any clear in the same cycle
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			standby <= 1'b0;
		end else if (i_ce) begin
			if (i_standby_set) begin
				standby <= 1'b1;
			end else if (i_standby_clr || wake_idle || addr_hit) begin
				standby <= 1'b0;
			end
		end
	end

	assign o_standby_request = standby;

	////////////////////////////////////////////////////////////////////////////
	// Idle detection on the receiver input
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			idle_cnt <= 8'h00;
		end else if (tk) begin
			if (!rx_line || (i_idle_count_start_select && state != ST_HUNT)) begin
				idle_cnt <= 8'h00;
			end else if (!line_idle) begin
				idle_cnt <= idle_cnt + CNT_STEP;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			idle_armed <= 1'b0;
			o_idle_flag <= 1'b0;
		end else if (i_ce) begin
			if (pend_v && pend.full) begin
				idle_armed <= 1'b1;
			end else if (idle_set || wake_idle) begin
				idle_armed <= 1'b0;
			end
			if (idle_set) begin
				o_idle_flag <= 1'b1;
			end else if (i_idle_clr) begin
				o_idle_flag <= 1'b0;
			end
		end
	end

	// No request of any kind leaves while in standby
	assign o_rx_irq = !standby && ((o_receive_full_flag && i_rx_irq_enable) ||
		(o_idle_flag && i_idle_irq_enable));

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	a_stop_noise: assert property (stop_dec && !same3(smp[0], smp[1], rx_line) |=> pend_v && pend.noise)
		else $error("stop noise not reported");
	a_stop_framing: assert property (stop_dec |=> pend_v && (pend.framing == !$past(vote)))
		else $error("framing decision wrong");
	a_resync_edge: assert property (tk && (late || early) |=> rt == RT_NEXT)
		else $error("tick counter not realigned");
	a_stop_timing: assert property (stop_first && !resynced |-> ft == (i_nine_bit ? STOP_AT_9 : STOP_AT_8))
		else $error("stop sample at wrong tick");
	a_standby_irq: assert property (standby |-> !o_rx_irq)
		else $error("request raised in standby");
	a_standby_word: assert property (stop_dec && standby && !i_standby_clr |=> pend_v && !pend.full)
		else $error("full raised in standby");
	a_idle_wake: assert property (i_ce && wake_idle && !i_standby_set |=> !standby && !o_idle_flag[*2])
		else $error("idle wakeup wrong");
	a_addr_wake: assert property (i_ce && addr_hit && !i_standby_set |=> !standby ##[1:120] pend_v && pend.full)
		else $error("address wakeup wrong");
	a_idle_count: assert property (tk && !rx_line |=> idle_cnt == 8'h00)
		else $error("idle count not reset");
	a_loop_route: assert property (i_cfg.internal_loop_select && i_cfg.receive_source_select == SRC_LOOP
		|-> rx_line == (i_tx_out ^ i_cfg.receive_polarity))
		else $error("loop path wrong");
	a_pin_dir: assert property (i_cfg.internal_loop_select && i_cfg.receive_source_select == SRC_PIN &&
		i_cfg.single_pin_direction == DIR_IN |-> o_tx_pin_oe_n)
		else $error("transmit pin driven as input");
endmodule

/* rtl/uwr_pkg.sv */
// Purpose: Shared constants and types for the receive path with wakeup and routing
// Assumes: 16 sample ticks per bit, 8 or 9 data bits
// Notes:   All timing figures are in sample ticks except IDLE_ONES_8 and IDLE_ONES_9, which are in bit times
package uwr_pkg;
	localparam int TICKS_PER_BIT = 16;
	localparam int STOP_SAMPLE_OFFSET = 7;
	localparam int IDLE_ONES_8 = 10;
	localparam int IDLE_ONES_9 = 11;
	localparam int BUF_DEPTH = 2;

	// Tick numbers inside one bit time
	localparam logic [4:0] RT_FIRST = 5'h01;
	localparam logic [4:0] RT_NEXT  = 5'h02;
	localparam logic [4:0] RT_STEP  = 5'h01;
	localparam logic [4:0] RT_V1    = 5'h03;
	localparam logic [4:0] RT_V2    = 5'h05;
	localparam logic [4:0] RT_V3    = 5'h07;
	localparam logic [4:0] RT_S1    = 5'h08;
	localparam logic [4:0] RT_S2    = 5'h09;
	localparam logic [4:0] RT_S3    = 5'h0A;
	localparam logic [4:0] RT_LAST  = 5'h10;

	localparam logic [3:0] BITS_8   = 4'h8;
	localparam logic [3:0] BITS_9   = 4'h9;
	localparam logic [3:0] IDX_STEP = 4'h1;
	localparam logic [2:0] HIST_ONES = 3'h7;

	// Ticks from start edge to first stop sample: 151 and 167
	localparam logic [7:0] STOP_AT_8 = 8'((int'(BITS_8) + 1) * TICKS_PER_BIT + STOP_SAMPLE_OFFSET);
	localparam logic [7:0] STOP_AT_9 = 8'((int'(BITS_9) + 1) * TICKS_PER_BIT + STOP_SAMPLE_OFFSET);
	localparam logic [7:0] IDLE_TICKS_8 = 8'(IDLE_ONES_8 * TICKS_PER_BIT);
	localparam logic [7:0] IDLE_TICKS_9 = 8'(IDLE_ONES_9 * TICKS_PER_BIT);
	localparam logic [7:0] CNT_STEP = 8'h01;

	localparam logic WAKE_IDLE = 1'b0;
	localparam logic WAKE_ADDR = 1'b1;
	localparam logic SRC_LOOP  = 1'b0;
	localparam logic SRC_PIN   = 1'b1;
	localparam logic DIR_IN    = 1'b0;
	localparam logic DIR_OUT   = 1'b1;

	typedef enum logic [1:0] {ST_HUNT, ST_START, ST_DATA, ST_STOP} uwr_state_type;

	typedef struct packed {
		logic [8:0] data;
		logic       noise;
		logic       framing;
		logic       full;
	} uwr_rx_word_type;

	typedef struct packed {
		logic internal_loop_select;
		logic receive_source_select;
		logic single_pin_direction;
		logic receive_polarity;
		logic transmitter_enable;
	} uwr_route_cfg_type;
endpackage

/* rtl/uwr_route.sv */
// Purpose: Selects the receiver input and the transmit pin direction
// Assumes: Pin levels already resolved by the surrounding pad logic
// Notes:   Purely combinational
`timescale 1ns/100ps
module uwr_route (
	input  wire logic                       i_rx_pin,
	input  wire logic                       i_tx_pin,
	input  wire logic                       i_tx_out,
	input  wire uwr_pkg::uwr_route_cfg_type i_cfg,
	output logic                            o_rx_line,
	output logic                            o_tx_pin,
	output logic                            o_tx_pin_oe_n
);
	import uwr_pkg::*;

	logic raw;
	logic pin_listen;

	assign pin_listen = i_cfg.internal_loop_select && i_cfg.receive_source_select == SRC_PIN;

	always_comb begin
		if (!i_cfg.internal_loop_select) begin
			raw = i_rx_pin;
		end else if (i_cfg.receive_source_select == SRC_PIN) begin
			raw = i_tx_pin;
		end else begin
			raw = i_tx_out;
		end
	end

	// Polarity applies on every source; loop needs matching transmit polarity
	assign o_rx_line = raw ^ i_cfg.receive_polarity;
	assign o_tx_pin = i_tx_out;
	assign o_tx_pin_oe_n = !(i_cfg.transmitter_enable &&
		!(pin_listen && i_cfg.single_pin_direction == DIR_IN));
endmodule

/* rtl/uwr_buf2.sv */
// Purpose: Two-entry buffer between frame completion and the reader
// Assumes: One push and one pop per cycle at most
// Notes:   Ready is low only when both entries hold words
`timescale 1ns/100ps
module uwr_buf2 (
	input  wire logic                     i_ref_clk,
	input  wire logic                     i_rst,
	input  wire logic                     i_ce,
	input  wire logic                     i_valid,
	output logic                          o_ready,
	input  wire uwr_pkg::uwr_rx_word_type i_word,
	output logic                          o_valid,
	input  wire logic                     i_ready,
	output uwr_pkg::uwr_rx_word_type      o_word
);
	import uwr_pkg::*;

	uwr_rx_word_type mem [BUF_DEPTH];
	logic            wp;
	logic            rp;
	logic [1:0]      cnt;
	logic            push;
	logic            pop;

	assign o_ready = cnt != 2'(BUF_DEPTH);
	assign o_valid = cnt != 2'h0;
	assign o_word = mem[rp];
	assign push = i_ce && i_valid && o_ready;
	assign pop = i_ce && o_valid && i_ready;

	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem[wp] <= i_word;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
		end else begin
			if (push) begin
				wp <= ~wp;
			end
			if (pop) begin
				rp <= ~rp;
			end
			cnt <= cnt + 2'(push) - 2'(pop);
		end
	end
endmodule

/* bench/uwr_line_model.sv */
// Purpose: Remote serial sender driving the receive line
// Assumes: Line steps once per sample tick
// Notes:   Two idle bits follow each frame, so a new start is always seen
`timescale 1ns/100ps
module uwr_line_model (
	input  wire logic        i_clk,
	input  wire logic        i_tick,
	input  wire logic        i_go,
	input  wire logic [8:0]  i_data,
	input  wire logic        i_nine,
	input  wire logic [15:0] i_stop,
	input  wire logic [4:0]  i_bit_ticks,
	output logic             o_line,
	output logic             o_busy
);
	int b = 0;
	int p = 0;
	int n;
	initial begin
		o_line = 1'b1;
		o_busy = 1'b0;
	end
	always @(posedge i_clk) begin
		n = i_nine ? 9 : 8;
		if (i_tick && o_busy) begin
			p = p + 1;
			if (p == i_bit_ticks) begin
				p = 0;
				b = b + 1;
			end
			if (b > n + 3)
				o_busy <= 1'b0;
			// Gaps between frames stay short of an idle character
			o_line <= (b == 0) ? 1'b0 : (b <= n) ? i_data[b-1] : (b == n + 1 && p < 16) ? i_stop[p] : 1'b1;
		end else if (i_tick && i_go) begin
			b = 0;
			p = 0;
			o_busy <= 1'b1;
			o_line <= 1'b0;
		end
	end
endmodule

/* bench/testbench.sv */
// Purpose: Self-checking bench for the receive path
// Assumes: One sample tick every second clock
// Notes:   Ordinary frames come from a row table
`timescale 1ns/100ps
module testbench;
	import uwr_pkg::*;
	typedef struct {
		logic [8:0]  d;
		logic        nine;
		logic [15:0] stop;
		logic [4:0]  bt;
		int          src;
		logic        pol;
		logic        noise;
		logic        fr;
	} uwr_row_type;
	uwr_row_type       rows [11];
	logic              clk = 1'b0, rst = 1'b1, tick = 1'b0, go = 1'b0, nine = 1'b0, pol = 1'b0;
	logic              ren = 1'b0, wake = 1'b0, idle_count_start_select = 1'b0, sset = 1'b0, sclr = 1'b0;
	logic              iclr = 1'b0, oclr = 1'b0, rdy = 1'b0, ilie = 1'b0;
	logic [8:0]        d = 9'h000;
	logic [15:0]       stop = 16'hFFFF;
	logic [4:0]        bt = 5'h10;
	int                src = 0, n, fail_count = 0, compares = 0;
	logic              line, busy, lv, rx_pin, tx_pin, tx_out;
	logic              tx_o, oe_n, valid, full_f, idle_f, ovr, stby, irq;
	uwr_route_cfg_type cfg = 5'h01;
	uwr_rx_word_type   word;

	always #5 clk = ~clk;
	always @(negedge clk) tick = rst ? 1'b0 : ~tick;
	assign lv = pol ? ~line : line;
	assign rx_pin = (src == 0) ? lv : 1'b0;
	assign tx_out = (src == 1) ? lv : 1'b0;
	assign tx_pin = (src == 2) ? lv : 1'b0;

	uwr_line_model u_line (.i_clk(clk), .i_tick(tick), .i_go(go), .i_data(d), .i_nine(nine),
		.i_stop(stop), .i_bit_ticks(bt), .o_line(line), .o_busy(busy));
	uwr_rx dut (.i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_sample_tick(tick), .i_rx_pin(rx_pin),
		.i_tx_pin(tx_pin), .i_tx_out(tx_out), .o_tx_pin(tx_o), .o_tx_pin_oe_n(oe_n), .i_cfg(cfg),
		.i_receiver_enable(ren), .i_nine_bit(nine), .i_wake_select(wake),
		.i_idle_count_start_select(idle_count_start_select), .i_standby_set(sset), .i_standby_clr(sclr),
		.i_idle_clr(iclr), .i_overrun_clr(oclr), .i_rx_irq_enable(1'b1), .i_idle_irq_enable(ilie),
		.o_rx_word(word), .o_rx_valid(valid), .i_rx_ready(rdy), .o_receive_full_flag(full_f),
		.o_idle_flag(idle_f), .o_overrun(ovr), .o_standby_request(stby), .o_rx_irq(irq));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk_bits(input logic [11:0] g, input logic [11:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t bits got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_word(input uwr_rx_word_type g, input uwr_rx_word_type e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t word got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_int(input int g, input int e);
		compares++;
		if (g != e) begin
			fail_count++;
			$display("ERROR %0t latency got %0d exp %0d", $time, g, e);
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		// Let an edge pass so a following pulse never re-raises in the same step
		@(negedge clk);
	endtask
	task automatic send(input logic [8:0] dd, input logic nn, input logic [15:0] ss, input logic [4:0] b);
		while (busy) @(negedge clk);
		d = dd;
		nine = nn;
		stop = ss;
		bt = b;
		go = 1'b1;
		while (!busy) @(negedge clk);
		go = 1'b0;
	endtask
	task automatic wait_valid(output int k);
		k = 0;
		while (!valid && k < 3000) begin
			@(negedge clk);
			k++;
		end
		if (!valid) begin
			fail_count++;
			$display("ERROR %0t no word arrived", $time);
		end
	endtask
	task automatic end_sim;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		rows = '{'{9'h0A5, 0, 16'hFFFF, 5'h10, 0, 0, 0, 0}, '{9'h1C3, 1, 16'hFFFF, 5'h10, 0, 0, 0, 0},
			'{9'h05A, 0, 16'h01FF, 5'h10, 0, 0, 1, 0}, '{9'h012, 0, 16'h00FF, 5'h10, 0, 0, 1, 1},
			'{9'h000, 0, 16'h0000, 5'h10, 0, 0, 0, 1}, '{9'h055, 0, 16'hFFFF, 5'h11, 0, 0, 0, 0},
			'{9'h055, 0, 16'hFFFF, 5'h0F, 0, 0, 0, 0}, '{9'h03C, 0, 16'hFFFF, 5'h10, 1, 0, 0, 0},
			'{9'h0C3, 0, 16'hFFFF, 5'h10, 1, 1, 0, 0}, '{9'h096, 0, 16'hFFFF, 5'h10, 2, 0, 0, 0},
			'{9'h069, 0, 16'hFFFF, 5'h10, 2, 1, 0, 0}};
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		chk_bits({valid, full_f, idle_f, ovr, stby, irq}, 6'h00);
		cfg = 5'h1D;
		@(negedge clk);
		chk_bits({oe_n, tx_o}, {1'b0, tx_out});
		cfg = 5'h00;
		@(negedge clk);
		chk_bits(oe_n, 1'b1);
		// Receiver enable on before any looped traffic
		ren = 1'b1;
		// History restarts at zero, so give the line three idle samples first
		repeat (8) @(negedge clk);
		foreach (rows[i]) begin
			src = rows[i].src;
			pol = rows[i].pol;
			cfg = {src != 0, src == 2, src == 1, pol, 1'b1};
			@(negedge clk);
			chk_bits(oe_n, src == 2);
			send(rows[i].d, rows[i].nine, rows[i].stop, rows[i].bt);
			wait_valid(n);
			if (rows[i].bt == 5'h10)
				chk_int(n, 2 * (int'(rows[i].nine ? STOP_AT_9 : STOP_AT_8) + 3) + 1);
			chk_word(word, {rows[i].d, rows[i].noise, rows[i].fr, 1'b1});
			rdy = 1'b1;
			@(negedge clk);
			rdy = 1'b0;
		end
		// Reader stalls, so the third word has nowhere to go
		for (int k = 1; k <= 3; k++)
			send(9'(k * 17), 1'b0, 16'hFFFF, 5'h10);
		while (busy) @(negedge clk);
		chk_bits({valid, ovr}, 2'h3);
		for (int k = 1; k <= 2; k++) begin
			chk_word(word, {9'(k * 17), 3'h1});
			pulse(rdy);
		end
		pulse(oclr);
		chk_bits({valid, ovr}, 2'h0);
		wake = 1'b1;
		pulse(sset);
		// Neither frame carries the address mark; 9'h080 in nine-bit mode leaves bit 8 clear
		send(9'h012, 1'b0, 16'hFFFF, 5'h10);
		send(9'h080, 1'b1, 16'hFFFF, 5'h10);
		while (busy) @(negedge clk);
		chk_bits({stby, full_f, irq}, 3'h4);
		chk_word(word, {9'h012, 3'h0});
		pulse(rdy);
		chk_word(word, {9'h080, 3'h0});
		pulse(rdy);
		send(9'h0A5, 1'b0, 16'hFFFF, 5'h10);
		while (stby && busy) @(negedge clk);
		chk_bits({stby, valid}, 2'h0);
		wait_valid(n);
		chk_bits({full_f, irq}, 2'h3);
		chk_word(word, {9'h0A5, 3'h1});
		pulse(rdy);
		pulse(sset);
		pulse(sclr);
		chk_bits(stby, 1'b0);
		wake = 1'b0;
		for (int k = 0; k < 2; k++) begin
			idle_count_start_select = k[0];
			pulse(iclr);
			send(9'h0F0, 1'b0, 16'hFFFF, 5'h10);
			repeat (20) @(negedge clk);
			pulse(sset);
			while (busy) @(negedge clk);
			chk_bits(stby, 1'b1);
			chk_word(word, {9'h0F0, 3'h0});
			pulse(rdy);
			n = 0;
			while (stby && n < 900) begin
				@(negedge clk);
				n++;
			end
			chk_bits({stby, idle_f, full_f}, 3'h0);
			chk_bits(n < 180, k == 0);
		end
		repeat (400) @(negedge clk);
		chk_bits(idle_f, 1'b0);
		pulse(sset);
		repeat (3) @(negedge clk);
		chk_bits(stby, 1'b0);
		// Idle after a normal word raises the flag and its request
		ilie = 1'b1;
		send(9'h03C, 1'b0, 16'hFFFF, 5'h10);
		wait_valid(n);
		chk_word(word, {9'h03C, 3'h1});
		pulse(rdy);
		repeat (400) @(negedge clk);
		chk_bits({idle_f, irq}, 2'h3);
		wake = 1'b1;
		pulse(sset);
		chk_bits({stby, idle_f, irq}, 3'h6);
		send(9'h033, 1'b0, 16'hFFFF, 5'h10);
		while (busy) @(negedge clk);
		chk_bits({stby, valid, full_f}, 3'h6);
		// Reset in mid-run clears buffer, flags and standby
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		chk_bits({valid, full_f, idle_f, ovr, stby, irq}, 6'h00);
		end_sim;
	end

	initial begin
		#300000;
		fail_count++;
		end_sim;
	end
endmodule
